// ===== core/sps_pkg.sv
package sps_pkg;
	// current level select pairs {sel1, sel0}
	localparam logic [1:0] LVL_FULL  = 2'h0;
	localparam logic [1:0] LVL_SIXTY = 2'h1;
	localparam logic [1:0] LVL_FIFTH = 2'h2;
	localparam logic [1:0] LVL_OFF   = 2'h3;
	localparam int         WINDINGS  = 2;
	localparam int         STATES    = 8;
	localparam logic [2:0] RESET_IDX = 3'h0;

	typedef struct packed {
		logic       phase;
		logic       level_sel1;
		logic       level_sel0;
	} sps_winding_t;

	typedef struct packed {
		sps_winding_t a;
		sps_winding_t b;
	} sps_motor_t;

	// both windings forward at holding level until the first step
	localparam sps_motor_t RESET_OUT = 6'h36;

	typedef enum logic [1:0] {
		SPS_IDLE = 2'b00,
		SPS_RUN  = 2'b01
	} sps_state_t;
endpackage : sps_pkg

// ===== core/sps_winding_table.sv
`timescale 1ns/100ps
module sps_winding_table (
	// state index and run level
	input  wire logic [2:0]         idx_i,
	input  wire logic               moving_i,
	input  wire logic               run_full_i,
	// winding controls
	output sps_pkg::sps_motor_t     motor_o
);
	logic [1:0] run_lvl;
	logic [1:0] ena;
	logic [1:0] ph;

	always_comb begin
		run_lvl = run_full_i ? sps_pkg::LVL_FULL : sps_pkg::LVL_SIXTY;
		// energised and phase per winding, index 0 = A fwd / B fwd
		unique case (idx_i)
			3'h0: begin ena = 2'b11; ph = 2'b11; end
			3'h1: begin ena = 2'b10; ph = 2'b10; end
			3'h2: begin ena = 2'b11; ph = 2'b10; end
			3'h3: begin ena = 2'b01; ph = 2'b00; end
			3'h4: begin ena = 2'b11; ph = 2'b00; end
			3'h5: begin ena = 2'b10; ph = 2'b01; end
			3'h6: begin ena = 2'b11; ph = 2'b01; end
			3'h7: begin ena = 2'b01; ph = 2'b11; end
		endcase
		// 1 = forward current, 11 = zero, 00 = full
		motor_o.a.phase = ph[1];
		motor_o.b.phase = ph[0];
		// off winding zero; hold at fifth; run at sixty or full
		{motor_o.a.level_sel1, motor_o.a.level_sel0} =
			!ena[1] ? sps_pkg::LVL_OFF : (moving_i ? run_lvl : sps_pkg::LVL_FIFTH);
		{motor_o.b.level_sel1, motor_o.b.level_sel0} =
			!ena[0] ? sps_pkg::LVL_OFF : (moving_i ? run_lvl : sps_pkg::LVL_FIFTH);
	end
endmodule : sps_winding_table

// ===== core/sps_sequencer.sv
`timescale 1ns/100ps
// Summary of operation
// - each motor has two windings, each with its own driver output set
// - each winding gets a phase line and two current-select lines
// - current selects choose zero, one fifth, three fifths or full
// - zero turns winding off; fifth while holding; higher levels while rotating
// - rotation steps both windings through states; rate of change sets speed
// - document motor uses eight distinct half-step states before repeating
// - reverse rotation walks the same table upward instead of downward
// - phase 1 forward, 0 reverse; selects 00 full, 11 zero
// - downward order from A fwd/B fwd through eight states, full current
// - carriage motor skips states where a winding is off
module sps_sequencer (
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// document motor step control
	input  wire logic               doc_step_i,
	input  wire logic               doc_reverse_i,
	input  wire logic               doc_run_full_i,
	// carriage motor step control
	input  wire logic               car_step_i,
	input  wire logic               car_reverse_i,
	input  wire logic               car_run_full_i,
	// winding driver outputs
	output sps_pkg::sps_motor_t     doc_motor_o,
	output sps_pkg::sps_motor_t     car_motor_o
);
	logic [2:0]           doc_idx;
	logic [2:0]           next_doc_idx;
	logic [2:0]           car_idx;
	logic [2:0]           next_car_idx;
	sps_pkg::sps_state_t  doc_st;
	sps_pkg::sps_state_t  next_doc_st;
	sps_pkg::sps_state_t  car_st;
	sps_pkg::sps_state_t  next_car_st;
	sps_pkg::sps_motor_t  doc_tab;
	sps_pkg::sps_motor_t  car_tab;
	sps_pkg::sps_motor_t  doc_q;
	sps_pkg::sps_motor_t  car_q;
	logic                 doc_moving;
	logic                 car_moving;

	// downward walk adds the stride, upward (reverse) subtracts it; carriage strides two
	function automatic logic [2:0] sps_advance(input logic [2:0] idx, input logic rev,
		input logic [2:0] stride);
		sps_advance = rev ? 3'(idx - stride) : 3'(idx + stride);
	endfunction : sps_advance

	always_comb begin
		next_doc_idx = doc_idx;
		next_car_idx = car_idx;
		// downward in the table is the forward walk; reverse goes upward
		if (doc_step_i) begin
			next_doc_idx = sps_advance(doc_idx, doc_reverse_i, 3'h1);
		end
		// carriage stays on even indices, both windings always energised
		if (car_step_i) begin
			next_car_idx = sps_advance(car_idx, car_reverse_i, 3'h2);
		end
		next_doc_st = doc_step_i ? sps_pkg::SPS_RUN : sps_pkg::SPS_IDLE;
		next_car_st = car_step_i ? sps_pkg::SPS_RUN : sps_pkg::SPS_IDLE;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			doc_idx <= sps_pkg::RESET_IDX;
			car_idx <= sps_pkg::RESET_IDX;
			doc_st  <= sps_pkg::SPS_IDLE;
			car_st  <= sps_pkg::SPS_IDLE;
		end else begin
			doc_idx <= next_doc_idx;
			car_idx <= next_car_idx;
			doc_st  <= next_doc_st;
			car_st  <= next_car_st;
		end
	end

	// running level applies in the cycle a step lands; idle drops to holding
	always_comb begin
		unique case (doc_st)
			sps_pkg::SPS_IDLE: doc_moving = 1'b0;
			sps_pkg::SPS_RUN:  doc_moving = 1'b1;
			default:           doc_moving = 1'b0;
		endcase
		unique case (car_st)
			sps_pkg::SPS_IDLE: car_moving = 1'b0;
			sps_pkg::SPS_RUN:  car_moving = 1'b1;
			default:           car_moving = 1'b0;
		endcase
	end

	// one table per motor, each feeding two winding drivers
	sps_winding_table u_doc_table (
		.idx_i      (doc_idx),
		.moving_i   (doc_moving),
		.run_full_i (doc_run_full_i),
		.motor_o    (doc_tab)
	);

	sps_winding_table u_car_table (
		.idx_i      (car_idx),
		.moving_i   (car_moving),
		.run_full_i (car_run_full_i),
		.motor_o    (car_tab)
	);

	// registered outputs keep glitches off the driver control pins
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			doc_q <= sps_pkg::RESET_OUT;
			car_q <= sps_pkg::RESET_OUT;
		end else begin
			doc_q <= doc_tab;
			car_q <= car_tab;
		end
	end

	assign doc_motor_o = doc_q;
	assign car_motor_o = car_q;
endmodule : sps_sequencer

// ===== testbench/sps_sequencer_sva.sv
`timescale 1ns/100ps
module sps_sequencer_sva (
	// clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// step controls
	input  wire logic                doc_step_i,
	input  wire logic                doc_run_full_i,
	input  wire logic                car_step_i,
	// winding controls
	input  wire sps_pkg::sps_motor_t doc_motor_o,
	input  wire sps_pkg::sps_motor_t car_motor_o
);
	wire logic [3:0] dl = {doc_motor_o[4:3], doc_motor_o[1:0]};
	wire logic [3:0] cl = {car_motor_o[4:3], car_motor_o[1:0]};
	// phase and off flag: adjacent states always differ here
	wire logic [3:0] dp = {doc_motor_o[5], &dl[3:2], doc_motor_o[2], &dl[1:0]};
	wire logic [1:0] cp = {car_motor_o[5], car_motor_o[2]};
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// levels show two edges after the step; run level follows the next cycle's select
	a_doc_hold: assert property (!doc_step_i |=> ##1 (dl[3] && dl[1]))
		else $error("doc hold level");
	a_doc_full: assert property (doc_step_i ##1 doc_run_full_i |=>
		dl inside {4'h0, 4'h3, 4'hC, 4'hF}) else $error("doc full level");
	a_doc_sixty: assert property (doc_step_i ##1 !doc_run_full_i |=> (dl[2] && dl[0]))
		else $error("doc sixty level");
	a_car_hold: assert property (!car_step_i |=> ##1 (cl == 4'hA))
		else $error("car hold level");
	a_doc_moves: assert property (doc_step_i |=> ##1 dp != $past(dp))
		else $error("doc no move");
	a_doc_still: assert property (!doc_step_i |=> ##1 $stable(dp))
		else $error("doc moved");
	a_car_moves: assert property (car_step_i |=> ##1 cp != $past(cp))
		else $error("car no move");
	a_car_still: assert property (!car_step_i |=> ##1 $stable(cp))
		else $error("car moved");
endmodule : sps_sequencer_sva

// ===== testbench/sps_winding_driver.sv
`timescale 1ns/100ps
module sps_winding_driver (
	input  wire sps_pkg::sps_winding_t w_i,
	output logic [6:0]                 pct_o
);
	always_comb begin
		case ({w_i.level_sel1, w_i.level_sel0})
			2'h0: pct_o = 7'h64;
			2'h1: pct_o = 7'h3C;
			2'h2: pct_o = 7'h14;
			default: pct_o = 7'h00;
		endcase
	end
endmodule : sps_winding_driver

// ===== testbench/tb_stepper_phase_sequencer.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin miscompares++; \
	$display("ERROR %s expected %h seen %h", n, e, s); end end
module tb_stepper_phase_sequencer;
	logic clk_i, rst_i, doc_step_i, doc_reverse_i, doc_run_full_i;
	logic car_step_i, car_reverse_i, car_run_full_i;
	logic [5:0] in_v = 6'h00;
	sps_pkg::sps_motor_t doc_motor_o, car_motor_o;
	logic [6:0] pa, pb;
	logic [2:0] di, ci;
	logic dm, cm;
	logic [5:0] de, ce;
	int checks = 0, miscompares = 0;
	assign {doc_step_i, doc_reverse_i, doc_run_full_i,
		car_step_i, car_reverse_i, car_run_full_i} = in_v;
	sps_sequencer sps_sequencer_inst (.clk_i, .rst_i, .doc_step_i, .doc_reverse_i, .doc_run_full_i,
		.car_step_i, .car_reverse_i, .car_run_full_i, .doc_motor_o, .car_motor_o);
	sps_winding_driver car_a (.w_i(car_motor_o.a), .pct_o(pa));
	sps_winding_driver car_b (.w_i(car_motor_o.b), .pct_o(pb));
	function automatic logic [5:0] tbl(input logic [2:0] i, input logic m, input logic f);
		logic [7:0] a_ph;
		logic [7:0] a_off;
		logic [7:0] b_ph;
		logic [7:0] b_off;
		logic [1:0] r;
		// one bit per table index: phase forward, winding off
		a_ph  = 8'h87;
		a_off = 8'h88;
		b_ph  = 8'hE1;
		b_off = 8'h22;
		r = m ? (f ? sps_pkg::LVL_FULL : sps_pkg::LVL_SIXTY) : sps_pkg::LVL_FIFTH;
		return {a_ph[i], (a_off[i] ? sps_pkg::LVL_OFF : r),
			b_ph[i], (b_off[i] ? sps_pkg::LVL_OFF : r)};
	endfunction : tbl
	always @(posedge clk_i) begin
		de <= rst_i ? 6'h36 : tbl(di, dm, doc_run_full_i);
		ce <= rst_i ? 6'h36 : tbl(ci, cm, car_run_full_i);
		dm <= doc_step_i & ~rst_i;
		cm <= car_step_i & ~rst_i;
		di <= rst_i ? 3'h0 : di + (doc_step_i ? (doc_reverse_i ? 3'h7 : 3'h1) : 3'h0);
		ci <= rst_i ? 3'h0 : ci + (car_step_i ? (car_reverse_i ? 3'h6 : 3'h2) : 3'h0);
		#1;
		`CHK("doc_motor_o", de, doc_motor_o)
		`CHK("car_motor_o", ce, car_motor_o)
		`CHK("car_on", 1'b1, pa != 7'h00 && pb != 7'h00)
	end
	task automatic print_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	task automatic drv(input logic [5:0] v);
		@(posedge clk_i);
		#2 in_v = v;
	endtask : drv
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	initial begin
		#100000;
		miscompares++;
		print_verdict;
	end
	initial begin
		logic [5:0] v;
		logic [1:0] f;
		rst_i = 1'b1;
		void'($urandom(24));
		repeat (2) @(posedge clk_i);
		#2 rst_i = 1'b0;
		// first trials: nine back-to-back steps, wrapping the table each way
		for (int t = 0; t < 80; t++) begin
			f = 2'($urandom);
			for (int k = 0; k < 9; k++) begin
				v = (t < 4) ? {1'b1, t[0], 2'h1, t[1], 1'b0} : 6'($urandom);
				drv({v[5:4], f[0], v[2:1], f[1]});
			end
			repeat (2) drv({2'h0, f[0], 2'h0, f[1]});
		end
		// mid-run reset while both motors step; stepping resumes from index zero
		repeat (3) drv(6'h24);
		rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#2 rst_i = 1'b0;
		repeat (4) drv(6'h24);
		repeat (2) drv(6'h00);
		print_verdict;
	end
endmodule : tb_stepper_phase_sequencer
bind sps_sequencer sps_sequencer_sva sps_sequencer_sva_inst (.clk_i, .rst_i, .doc_step_i,
	.doc_run_full_i, .car_step_i, .doc_motor_o, .car_motor_o);
